/* File: design/thd_monitor.sv */
// Harmonic distortion monitor: ratio calc, elements, events and registers
// Contract
// - Evaluate each channel from 32 spectrum bins.
// - Power ratio: harmonics two-31 squared over fundamental; the code divides by the fundamental squared.
// - Shared mode, amplitude code 1 default, power 2.
// - Five spectrum channels, each every 5 ms.
// - Per-element enable, 0 enables, default enabled.
// - Thresholds in 0.01 % steps, default 10.00 %.
// - Phase element picks up on any phase.
// - Residual element uses its own channel only.
// - Drop out below fixed 97 % of threshold.
// - One threshold shared by all three phases.
// - START only while blocking is inactive.
// - START and ALARM per element, plus BLOCKED.
// - Eight setting groups, selected by one source.
// - Every START, ALARM or any-element BLOCKED change gives stamped ON/OFF event.
// - Resettable START, ALARM and BLOCKED counters.
// - Status code normal, start, alarm, blocked.
// - Mode selection unaffected by setting group.
// - Pre-fault data from 20 ms average.
// - Group and blocking act on enabled elements only.
// - Alarm delay in 5 ms steps, default 10 s.
// - Blocked pick-up raises BLOCKED, nothing further.
// - Late blocking clears START like a drop-out.
`timescale 1ns/1ps
module thd_monitor (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Avalon-MM register slave
  input wire thd_monitor_pkg::avm_req_s i_avm,
  output logic [31:0] o_avm_readdata,
  output logic o_avm_waitrequest,
  // Spectrum stream, blocking and group selection
  input wire thd_monitor_pkg::spec_s i_spec,
  input wire logic i_block,
  input wire logic [2:0] i_group,
  // Element outputs
  output logic [2:0] o_start,
  output logic [2:0] o_alarm,
  output logic [2:0] o_blocked,
  output logic [1:0] o_status,
  output thd_monitor_pkg::evt_s o_event
);
  import thd_monitor_pkg::*;

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [1:0] mode;
    grp_s [N_GRP-1:0] grp;
    logic [36:0] harm;
    logic [15:0] fund;
    logic eval;
    logic [N_CH-1:0][15:0] thd;
    logic [N_CH-1:0][AVG_DEPTH-1:0][15:0] hist;
    logic [1:0] hptr;
    logic [N_CH-1:0][15:0] pre;
    logic [N_EL-1:0] pick;
    logic [N_EL-1:0] start;
    logic [N_EL-1:0] alarm;
    logic [N_EL-1:0] blk;
    logic [N_EL-1:0][19:0] tmr;
    logic [1:0] status;
    logic [14:0] mdiv;
    logic [31:0] ms;
    logic [15:0] cnt_start;
    logic [15:0] cnt_alarm;
    logic [15:0] cnt_blk;
    evt_s evt;
  } st_s;

  st_s s_q;
  st_s s_d;
  grp_s cfg;
  logic req;
  logic clr;
  logic [31:0] rd_v;
  logic [31:0] sq;
  logic [36:0] harm_n;
  logic [6:0] old_v;
  logic [6:0] new_v;
  logic [N_EL-1:0] over_v;
  logic [N_EL-1:0] below_v;
  logic [17:0] asum;

  // Integer square root, bit by bit
  function automatic logic [18:0] isqrt(input logic [36:0] v);
    logic [18:0] r;
    logic [18:0] t;
    r = '0;
    for (int i = 18; i >= 0; i--) begin
      t = r | (19'h1 << i);
      if (38'(t) * 38'(t) <= 38'(v)) begin
        r = t;
      end
    end
    return r;
  endfunction

  // Distortion in 0.01 % units, saturated; no harmonics reads as zero, otherwise no fundamental reads as maximum
  function automatic logic [15:0] ratio(input logic pw,
                                        input logic [36:0] h,
                                        input logic [15:0] f);
    logic [51:0] num;
    logic [51:0] den;
    logic [51:0] q;
    num = pw ? 52'(h) * 52'(THD_SCALE)
             : 52'(isqrt(h)) * 52'(THD_SCALE);
    den = pw ? 52'(f) * 52'(f) : 52'(f);
    q = (den == '0) ? {52{1'b1}} : num / den;
    if (num == '0) begin
      q = '0;
    end
    return (q > 52'h0FFFF) ? 16'hFFFF : q[15:0];
  endfunction

  function automatic logic over(input logic [15:0] v, input logic [15:0] t);
    return v > t;
  endfunction

  // Hysteresis: fixed reset ratio relative to the setting
  function automatic logic below(input logic [15:0] v, input logic [15:0] t);
    return 32'(v) * 32'(FULL_PCT) < 32'(t) * 32'(RESET_PCT);
  endfunction

  function automatic logic is_tab(input logic [11:0] a,
                                  input logic [11:0] base);
    return a[11:5] == base[11:5] && a[4:2] < 3'(N_CH) && a[1:0] == 2'h0;
  endfunction

  function automatic logic is_grp(input logic [11:0] a);
    return a[11:8] == GRP_BASE[11:8] && a[1:0] == 2'h0;
  endfunction

  // Group settings follow the selector live; mode is held apart from them
  assign cfg = s_q.grp[i_group];

  always_comb begin
    s_d = s_q;
    s_d.eval = 1'b0;
    s_d.evt.valid = 1'b0;
    rd_v = '0;
    clr = 1'b0;
    sq = '0;
    harm_n = '0;
    old_v = '0;
    new_v = '0;
    over_v = '0;
    below_v = '0;
    asum = '0;

    // Millisecond time base for event stamps
    if (s_q.mdiv == MS_DIV_LAST) begin
      s_d.mdiv = '0;
      s_d.ms = s_q.ms + 32'h1;
    end else begin
      s_d.mdiv = s_q.mdiv + 15'h1;
    end

    // Bus: one wait cycle, then the answer; writes land on the release edge
    req = i_avm.read | i_avm.write;
    s_d.wreq = ~(req & s_q.wreq);
    if (req && s_q.wreq) begin
      if (i_avm.address == REG_CTRL) begin
        rd_v = 32'(s_q.mode);
      end else if (i_avm.address == REG_STATUS) begin
        rd_v = {18'h0, i_group, s_q.blk, s_q.alarm, s_q.start, s_q.status};
      end else if (i_avm.address == REG_CNT_START) begin
        rd_v = 32'(s_q.cnt_start);
      end else if (i_avm.address == REG_CNT_ALARM) begin
        rd_v = 32'(s_q.cnt_alarm);
      end else if (i_avm.address == REG_CNT_BLK) begin
        rd_v = 32'(s_q.cnt_blk);
      end else if (i_avm.address == REG_TIME) begin
        rd_v = s_q.ms;
      end else if (is_tab(i_avm.address, REG_THD_BASE)) begin
        rd_v = 32'(s_q.thd[i_avm.address[4:2]]);
      end else if (is_tab(i_avm.address, REG_PRE_BASE)) begin
        rd_v = 32'(s_q.pre[i_avm.address[4:2]]);
      end else if (is_grp(i_avm.address)) begin
        case (i_avm.address[4:2])
          GF_DIS: begin
            rd_v = 32'(s_q.grp[i_avm.address[7:5]].dis);
          end
          3'h1, 3'h2, 3'h3: begin
            rd_v = 32'(s_q.grp[i_avm.address[7:5]]
                       .thr[2'(i_avm.address[4:2] - GF_THR)]);
          end
          3'h4, 3'h5, 3'h6: begin
            rd_v = 32'(s_q.grp[i_avm.address[7:5]]
                       .dly[2'(i_avm.address[4:2] - GF_DLY)]);
          end
          default: begin
            rd_v = '0;
          end
        endcase
      end
      s_d.rdata = rd_v;
    end
    if (i_avm.write && !s_q.wreq) begin
      if (i_avm.address == REG_CTRL) begin
        s_d.mode = i_avm.writedata[1:0];
        clr = i_avm.writedata[CTRL_CLR_BIT];
      end else if (is_grp(i_avm.address)) begin
        case (i_avm.address[4:2])
          GF_DIS: begin
            s_d.grp[i_avm.address[7:5]].dis =
              i_avm.writedata[N_EL-1:0];
          end
          3'h1, 3'h2, 3'h3: begin
            s_d.grp[i_avm.address[7:5]]
              .thr[2'(i_avm.address[4:2] - GF_THR)] =
              i_avm.writedata[15:0];
          end
          3'h4, 3'h5, 3'h6: begin
            s_d.grp[i_avm.address[7:5]]
              .dly[2'(i_avm.address[4:2] - GF_DLY)] =
              i_avm.writedata[19:0];
          end
          default: begin
          end
        endcase
      end
    end
    if (clr) begin
      s_d.cnt_start = '0;
      s_d.cnt_alarm = '0;
      s_d.cnt_blk = '0;
    end

    // Spectrum: bin 0 is DC and restarts a channel, bin 1 the fundamental
    if (i_spec.valid) begin
      sq = 32'(i_spec.mag) * 32'(i_spec.mag);
      harm_n = (i_spec.bin == 5'h0) ? '0 : s_q.harm;
      if (i_spec.bin > BIN_FUND) begin
        harm_n = harm_n + 37'(sq);
      end
      s_d.harm = harm_n;
      if (i_spec.bin == BIN_FUND) begin
        s_d.fund = i_spec.mag;
      end
      if (i_spec.bin == BIN_LAST && i_spec.chan < 3'(N_CH)) begin
        s_d.thd[i_spec.chan] =
          ratio(s_q.mode == MODE_POWER, harm_n, s_q.fund);
        s_d.eval = (i_spec.chan == CH_LAST);
      end
    end

    // Element evaluation once per spectrum frame
    if (s_q.eval) begin
      old_v = {|s_q.blk, s_q.alarm, s_q.start};
      over_v[0] = over(s_q.thd[0], cfg.thr[0]) |
                  over(s_q.thd[1], cfg.thr[0]) |
                  over(s_q.thd[2], cfg.thr[0]);
      below_v[0] = below(s_q.thd[0], cfg.thr[0]) &
                   below(s_q.thd[1], cfg.thr[0]) &
                   below(s_q.thd[2], cfg.thr[0]);
      over_v[1] = over(s_q.thd[3], cfg.thr[1]);
      below_v[1] = below(s_q.thd[3], cfg.thr[1]);
      over_v[2] = over(s_q.thd[4], cfg.thr[2]);
      below_v[2] = below(s_q.thd[4], cfg.thr[2]);
      for (int e = 0; e < N_EL; e++) begin
        s_d.pick[e] = ~cfg.dis[e] &
                      (over_v[e] | (s_q.pick[e] & ~below_v[e]));
        s_d.start[e] = s_d.pick[e] & ~i_block;
        s_d.blk[e] = s_d.pick[e] & i_block;
        // Timer counts frames held; saturates rather than wraps
        if (s_d.start[e] && s_q.start[e]) begin
          s_d.tmr[e] = (&s_q.tmr[e]) ? s_q.tmr[e] : s_q.tmr[e] + 20'h1;
        end else begin
          s_d.tmr[e] = '0;
        end
        s_d.alarm[e] = s_d.start[e] & (s_d.tmr[e] >= cfg.dly[e]);
      end
      new_v = {|s_d.blk, s_d.alarm, s_d.start};

      if (|s_d.blk) begin
        s_d.status = ST_BLOCKED;
      end else if (|s_d.alarm) begin
        s_d.status = ST_ALARM;
      end else if (|s_d.start) begin
        s_d.status = ST_START;
      end else begin
        s_d.status = ST_NORMAL;
      end

      // Pre-fault snapshot uses the window before this frame
      if (|(s_d.start & ~s_q.start) || |(s_d.blk & ~s_q.blk)) begin
        for (int c = 0; c < N_CH; c++) begin
          asum = '0;
          for (int k = 0; k < AVG_DEPTH; k++) begin
            asum = asum + 18'(s_q.hist[c][k]);
          end
          s_d.pre[c] = 16'(asum / 18'(AVG_DEPTH));
        end
      end
      for (int c = 0; c < N_CH; c++) begin
        s_d.hist[c][s_q.hptr] = s_q.thd[c];
      end
      s_d.hptr = s_q.hptr + 2'h1;

      // A clear in the same cycle loses to the new occurrence
      s_d.cnt_start = s_d.cnt_start +
                      16'(|(s_d.start & ~s_q.start));
      s_d.cnt_alarm = s_d.cnt_alarm + 16'(|(s_d.alarm & ~s_q.alarm));
      s_d.cnt_blk = s_d.cnt_blk + 16'(|(s_d.blk & ~s_q.blk));

      if (new_v != old_v) begin
        s_d.evt.valid = 1'b1;
        s_d.evt.changed = new_v ^ old_v;
        s_d.evt.level = new_v;
        s_d.evt.stamp = s_q.ms;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.wreq <= 1'b1;
      s_q.mode <= MODE_AMPLITUDE;
      for (int g = 0; g < N_GRP; g++) begin
        s_q.grp[g] <= GRP_RESET;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign o_avm_readdata = s_q.rdata;
  assign o_avm_waitrequest = s_q.wreq;
  assign o_start = s_q.start;
  assign o_alarm = s_q.alarm;
  assign o_blocked = s_q.blk;
  assign o_status = s_q.status;
  assign o_event = s_q.evt;

  // Checks
  logic [19:0] dly0_cur;
  logic [6:0] out_v;
  assign dly0_cur = cfg.dly[0];
  assign out_v = {|s_q.blk, s_q.alarm, s_q.start};

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_start_blk_excl:
    assert property ((s_q.start & s_q.blk) == 3'h0)
      else $error("start and blocked high together");
  a_alarm_needs_start:
    assert property ((s_q.alarm & ~s_q.start) == 3'h0)
      else $error("alarm without start");
  a_disabled_quiet:
    assert property (s_q.eval && cfg.dis[0] |=> !s_q.pick[0] && !s_q.start[0])
      else $error("disabled phase element active");
  a_block_clears:
    assert property (s_q.eval && i_block |=> s_q.start == 3'h0 &&
                     s_q.blk == s_q.pick)
      else $error("start survived blocking");
  a_phase_pickup:
    assert property (s_q.eval && !cfg.dis[0] &&
                     (s_q.thd[1] > cfg.thr[0]) |=> s_q.pick[0])
      else $error("phase element missed pick-up");
  a_res_pickup:
    assert property (s_q.eval && !cfg.dis[1] &&
                     (s_q.thd[3] > cfg.thr[1]) |=> s_q.pick[1])
      else $error("residual one missed pick-up");
  a_alarm_delay:
    assert property ($rose(s_q.alarm[0]) |->
                     s_q.tmr[0] >= $past(dly0_cur))
      else $error("alarm before delay expired");
  a_event_change:
    assert property ($changed(out_v) |->
                     s_q.evt.valid && s_q.evt.changed ==
                     (out_v ^ $past(out_v)))
      else $error("output change without event");
  a_status_code:
    assert property (s_q.eval ##1 (|s_q.blk) |-> s_q.status == ST_BLOCKED)
      else $error("status not blocked");
  a_mode_static:
    assert property (!(i_avm.write && !s_q.wreq &&
                       i_avm.address == REG_CTRL) |=> $stable(s_q.mode))
      else $error("mode changed without write");
  a_bus_answer:
    assert property (req && s_q.wreq |=> !s_q.wreq)
      else $error("waitrequest held past one cycle");

  c_alarm_rise: cover property ($rose(s_q.alarm[0]));
  c_block_rise: cover property ($rose(s_q.blk[0]));
  c_power_eval: cover property (s_q.eval && s_q.mode == MODE_POWER);
  c_group_switch: cover property (s_q.start[0] && $changed(i_group));
endmodule

/* File: design/thd_monitor_pkg.sv */
// Package: constants, register map and carrier types of the THD monitor
package thd_monitor_pkg;
  localparam int N_CH = 5;
  localparam int N_EL = 3;
  localparam int N_GRP = 8;
  localparam int N_BIN = 32;
  localparam logic [4:0] BIN_FUND = 5'h01;
  localparam logic [4:0] BIN_LAST = 5'(N_BIN - 1);
  localparam logic [2:0] CH_LAST = 3'(N_CH - 1);
  // Calculation mode codes
  localparam logic [1:0] MODE_AMPLITUDE = 2'h1;
  localparam logic [1:0] MODE_POWER = 2'h2;
  // Condition codes
  localparam logic [1:0] ST_NORMAL = 2'h0;
  localparam logic [1:0] ST_START = 2'h1;
  localparam logic [1:0] ST_ALARM = 2'h2;
  localparam logic [1:0] ST_BLOCKED = 2'h3;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int STAMP_RES_MS = 1;
  localparam int TIME_BASE_MS = 5;
  localparam int ALARM_STEP_MS = 5;
  localparam int AVG_WINDOW_MS = 20;
  localparam int DELAY_DEFAULT_MS = 10000;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * STAMP_RES_MS;
  localparam logic [14:0] MS_DIV_LAST = 15'(CYC_PER_MS - 1);
  localparam int AVG_DEPTH = AVG_WINDOW_MS / TIME_BASE_MS;
  // Ratio scaling: thresholds and results in 0.01 % units
  localparam int THD_SCALE = 10000;
  localparam int RESET_PCT = 97;
  localparam int FULL_PCT = 100;
  // Reset values
  localparam logic [2:0] DIS_RESET = 3'h0;
  localparam logic [15:0] THR_RESET = 16'h03E8;
  localparam logic [19:0] DLY_RESET = 20'(DELAY_DEFAULT_MS / ALARM_STEP_MS);
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CNT_START = 12'h008;
  localparam logic [11:0] REG_CNT_ALARM = 12'h00C;
  localparam logic [11:0] REG_CNT_BLK = 12'h010;
  localparam logic [11:0] REG_TIME = 12'h014;
  localparam logic [11:0] REG_THD_BASE = 12'h020;
  localparam logic [11:0] REG_PRE_BASE = 12'h040;
  localparam logic [11:0] GRP_BASE = 12'h100;
  // Field positions
  localparam int CTRL_CLR_BIT = 8;
  localparam logic [2:0] GF_DIS = 3'h0;
  localparam logic [2:0] GF_THR = 3'h1;
  localparam logic [2:0] GF_DLY = 3'h4;

  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [31:0] writedata;
  } avm_req_s;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [4:0] bin;
    logic [15:0] mag;
  } spec_s;

  typedef struct packed {
    logic [N_EL-1:0] dis;
    logic [N_EL-1:0][15:0] thr;
    logic [N_EL-1:0][19:0] dly;
  } grp_s;

  typedef struct packed {
    logic valid;
    logic [6:0] changed;
    logic [6:0] level;
    logic [31:0] stamp;
  } evt_s;

  localparam grp_s GRP_RESET =
    '{DIS_RESET, {N_EL{THR_RESET}}, {N_EL{DLY_RESET}}};
endpackage

/* File: verif/spectrum_source.sv */
// Spectrum front end model: streams one five-channel frame per request
`timescale 1ns/1ps
module spectrum_source
  import thd_monitor_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Frame request and bin contents
  input wire logic i_go,
  input wire logic [N_CH-1:0][15:0] i_fund,
  input wire logic [N_CH-1:0][15:0] i_harm,
  // Spectrum stream
  output thd_monitor_pkg::spec_s o_spec,
  output logic o_busy
);
  logic [7:0] idx_q;
  logic run_q;
  logic [15:0] last_q;
  logic [2:0] ch;
  logic [4:0] bn;
  logic [15:0] mag;

  assign ch = idx_q[7:5];
  assign bn = idx_q[4:0];
  // Only the third harmonic carries energy, so the expected ratio is exact
  always_comb begin
    mag = 16'h0000;
    if (bn == 5'h00) begin
      mag = 16'h0055;
    end else if (bn == BIN_FUND) begin
      mag = i_fund[ch];
    end else if (bn == 5'h03) begin
      mag = i_harm[ch];
    end
  end
  // Between frames the magnitude toggles so no stale bin can be mistaken for data
  assign o_spec = '{valid: run_q, chan: ch, bin: bn,
                    mag: run_q ? mag : ~last_q};
  assign o_busy = run_q;
  // Five channels in order, 32 bins each, bins back to back
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      idx_q <= 8'h00;
      last_q <= 16'h0000;
    end else begin
      last_q <= o_spec.mag;
      if (run_q) begin
        idx_q <= idx_q + 8'h01;
        if (idx_q == 8'h9F) begin
          run_q <= 1'b0;
        end
      end else if (i_go) begin
        run_q <= 1'b1;
        idx_q <= 8'h00;
      end
    end
  end
endmodule

/* File: verif/test_thd_monitor.sv */
// Self-checking bench for the harmonic distortion monitor
`timescale 1ns/1ps
module test_thd_monitor;
  import thd_monitor_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  avm_req_s avm = '0;
  logic [31:0] rdata;
  logic wreq;
  spec_s spec;
  logic blk = 1'b0;
  logic [2:0] grp = 3'h0;
  logic [2:0] start;
  logic [2:0] alarm;
  logic [2:0] blocked;
  logic [1:0] status;
  evt_s evt;
  evt_s ev_q;
  logic go = 1'b0;
  logic busy;
  logic [N_CH-1:0][15:0] fund = {N_CH{16'h03E8}};
  logic [N_CH-1:0][15:0] harm = '0;
  logic [31:0] q;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int ev_cyc = 0;

  always #25 i_clk_sys = ~i_clk_sys;
  // Counts the edges the design runs on, to predict the event stamp
  always @(posedge i_clk_sys) begin
    if (i_rst_n) begin
      cyc <= cyc + 1;
    end
  end
  always @(posedge i_clk_sys) begin
    if (evt.valid === 1'b1) begin
      ev_q <= evt;
      ev_cyc <= cyc;
    end
  end

  thd_monitor u_thd_monitor (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_avm(avm), .o_avm_readdata(rdata), .o_avm_waitrequest(wreq),
    .i_spec(spec), .i_block(blk), .i_group(grp), .o_start(start),
    .o_alarm(alarm), .o_blocked(blocked), .o_status(status),
    .o_event(evt));
  spectrum_source u_spectrum_source (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_go(go), .i_fund(fund), .i_harm(harm),
    .o_spec(spec), .o_busy(busy));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    avm <= '{read: !w, write: w, address: a, writedata: d};
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      failures++;
      end_sim();
    end
    q = rdata;
    avm <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  function automatic logic [N_CH-1:0][15:0] one(input int c,
                                                input logic [15:0] v);
    logic [N_CH-1:0][15:0] h;
    h = '0;
    h[c] = v;
    return h;
  endfunction

  // Streams a whole frame, then lets evaluation settle before sampling
  task automatic frame(input logic [N_CH-1:0][15:0] h);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    harm <= h;
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (busy !== 1'b0 && n < 400);
    if (busy !== 1'b0) begin
      failures++;
      end_sim();
    end
    repeat (3) @(negedge i_clk_sys);
  endtask

  task automatic outs(input logic [10:0] e);
    chk({21'h0, start, alarm, blocked, status}, {21'h0, e});
  endtask

  // Blocking and group change only just after an edge
  task automatic setin(input logic b, input logic [2:0] g);
    @(posedge i_clk_sys);
    blk <= b;
    grp <= g;
  endtask

  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(negedge i_clk_sys);
    outs({9'h000, ST_NORMAL});
    rd(REG_CTRL, 32'h1);
    for (int g = 0; g < N_GRP; g++) begin
      rd(GRP_BASE + 12'(g * 32) + 12'h004, 32'h3E8);
      rd(GRP_BASE + 12'(g * 32) + 12'h010, 32'h7D0);
      rd(GRP_BASE + 12'(g * 32), 32'h0);
    end
    rd(12'hFFC, 32'h0);
    $display("test reset values done");
    for (int e = 0; e < N_EL; e++) wr(GRP_BASE + 12'(16 + 4 * e), 32'h2);
    frame(one(1, 16'h00C8));
    outs({3'b001, 6'h00, ST_START});
    chk({25'h0, ev_q.changed, ev_q.level}, {25'h0, 14'h0081});
    rd(REG_THD_BASE + 12'h004, 32'h7D0);
    repeat (2) frame(one(1, 16'h00C8));
    outs({3'b001, 3'b001, 3'b000, ST_ALARM});
    frame(one(1, 16'h0062));
    outs({3'b001, 3'b001, 3'b000, ST_ALARM});
    frame(one(1, 16'h0060));
    outs({9'h000, ST_NORMAL});
    chk({25'h0, ev_q.changed, ev_q.level}, {25'h0, 14'h0480});
    frame(one(2, 16'h0064));
    outs({9'h000, ST_NORMAL});
    $display("test phase element done");
    wr(GRP_BASE + 12'h00C, 32'hBB8);
    frame({16'h00C8, 16'h00C8, 48'h0});
    outs({3'b010, 6'h00, ST_START});
    $display("test residual elements done");
    wr(REG_CTRL, {30'h0, MODE_POWER});
    frame(one(0, 16'h00C8));
    outs({9'h000, ST_NORMAL});
    rd(REG_THD_BASE, 32'h190);
    frame(one(0, 16'h0190));
    outs({3'b001, 6'h00, ST_START});
    rd(REG_THD_BASE, 32'h640);
    wr(GRP_BASE + 12'h024, 32'hBB8);
    setin(1'b0, 3'h1);
    rd(REG_CTRL, {30'h0, MODE_POWER});
    frame(one(0, 16'h0190));
    outs({9'h000, ST_NORMAL});
    setin(1'b0, 3'h0);
    wr(REG_CTRL, {30'h0, MODE_AMPLITUDE});
    $display("test mode and groups done");
    // Blocking is raised a whole frame ahead of any alarm expiry
    setin(1'b1, 3'h0);
    frame(one(0, 16'h00C8));
    outs({6'h00, 3'b001, ST_BLOCKED});
    setin(1'b0, 3'h0);
    frame(one(0, 16'h00C8));
    outs({3'b001, 6'h00, ST_START});
    setin(1'b1, 3'h0);
    frame(one(0, 16'h00C8));
    outs({6'h00, 3'b001, ST_BLOCKED});
    setin(1'b0, 3'h0);
    $display("test blocking done");
    rd(REG_CNT_BLK, 32'h2);
    wr(REG_CTRL, 32'h101);
    rd(REG_CNT_START, 32'h0);
    rd(REG_CNT_BLK, 32'h0);
    frame(one(0, 16'h0000));
    outs({9'h000, ST_NORMAL});
    repeat (3) frame(one(0, 16'h00C8));
    outs({3'b001, 3'b001, 3'b000, ST_ALARM});
    rd(REG_CNT_START, 32'h1);
    rd(REG_CNT_ALARM, 32'h1);
    rd(REG_PRE_BASE, 32'h5DC);
    rd(REG_STATUS, 32'h26);
    // Let the millisecond count move so the stamp is not trivially zero
    repeat (20000) @(posedge i_clk_sys);
    wr(GRP_BASE, 32'h1);
    frame(one(0, 16'h00C8));
    outs({9'h000, ST_NORMAL});
    chk(ev_q.stamp, 32'((ev_cyc - 1) / CYC_PER_MS));
    $display("test counters and disable done");
    end_sim();
  end
endmodule
